// [design/data_space_decode.sv]
/*
  Combinational decoder for one internal data access: which space,
  which register bank, bit-area and bit-addressable special register.
  Assumes the caller registers the results on its own clock.
*/
`timescale 1ns/1ps
`include "mem_space_defines.svh"

module data_space_decode (
  // access request
  input  wire logic [7:0]  addr,
  input  wire logic        indirect,
  input  wire logic        reg_form,
  input  wire logic [2:0]  reg_num,
  input  wire logic [1:0]  bank,
  // results
  output mem_space_pkg::data_space_t space,
  output logic [7:0]       eff_addr,
  output logic             in_bank_area,
  output logic             in_bit_area,
  output logic             sfr_bit_ok
);
  // space selection by address and access type
  always_comb
  begin
    eff_addr = addr;
    if (reg_form)
      // bank base is bank number times eight
      eff_addr = {3'h0, bank, reg_num};
    if (eff_addr <= `LOWER_LAST)
      space = mem_space_pkg::SPACE_LOWER;
    else if (indirect)
      space = mem_space_pkg::SPACE_UPPER;
    else
      space = mem_space_pkg::SPACE_SPECIAL;
    in_bank_area = (eff_addr <= `BANK_AREA_LAST);
    in_bit_area = (eff_addr >= `BIT_AREA_FIRST) &&
                  (eff_addr <= `BIT_AREA_LAST);
    // only directly addressed specials ending in 0 or 8
    sfr_bit_ok = (space == mem_space_pkg::SPACE_SPECIAL) &&
                 (eff_addr[2:0] == 3'h0);
  end
endmodule

// [design/mem_space_decoder.sv]
/*
  Memory-space decoder and external bus sequencer for a small 8-bit
  core: fetch routing under the strap, multiplexed address/data bus,
  address latch strobe, data strobes, internal data decode, status word.
  Assumes the core supplies fetch and access requests one at a time and
  the external latch, ROM and RAM answer within one bus phase.
*/
// Overview of operation
// - after reset fetch starts at zero
// - interrupt vectors eight bytes apart from 0003
// - strap high: low 4k internal, rest external
// - strap low: all fetches external
// - fetch strobe only on external fetches
// - low port drives address, then floats, or drives write data on writes
// - latch strobe while low address valid
// - high port carries upper fetch address
// - external fetch address always 16 bits
// - separate read/write strobes, never write program
// - one or two byte data addresses
// - upper addresses split by access type
// - lowest 32 bytes four banks of eight
// - bank chosen by status bits per instruction
// - 16 bytes above banks bit addressable
// - upper block indirect only, lower both
// - specials direct only, x0/x8 bit addressable
// - parity flag tracks accumulator odd ones
// - status word holds flags, bank bits, parity
// - direct address is eight bit field
// - 4k internal ROM, 128 RAM, 64k spaces
// - internal addresses byte wide, pointer sixteen
`timescale 1ns/1ps
`include "mem_space_defines.svh"

module mem_space_decoder (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // strap pin, active low selects all-external fetch
  input  wire logic        EXTERNAL_FETCH_STRAP_N,
  // fetch request from the core
  input  wire logic        FETCH_REQ,
  input  wire logic [15:0] FETCH_ADDR,
  input  wire logic        VECTOR_REQ,
  input  wire logic [1:0]  VECTOR_NUM,
  // external data request from the core
  input  wire logic        XDATA_REQ,
  input  wire logic        XDATA_WRITE,
  input  wire logic        XDATA_WIDE,
  input  wire logic [7:0]  XDATA_ADDR8,
  input  wire logic [15:0] WIDE_DATA_POINTER,
  input  wire logic [7:0]  XDATA_WDATA,
  // internal data access from the core
  input  wire logic [7:0]  IDATA_ADDR,
  input  wire logic        IDATA_INDIRECT,
  input  wire logic        IDATA_REG_FORM,
  input  wire logic [2:0]  IDATA_REG_NUM,
  input  wire logic        INSTR_START,
  // status word inputs
  input  wire logic [7:0]  ACCUMULATOR,
  input  wire logic        PSW_WRITE,
  input  wire logic [7:0]  PSW_WDATA,
  // multiplexed low port, enable low while driving
  input  wire logic [7:0]  MULTIPLEXED_LOW_PORT_IN,
  output logic [7:0]       MULTIPLEXED_LOW_PORT_OUT,
  output logic             MULTIPLEXED_LOW_PORT_OE_N,
  // high port and strobes
  output logic [7:0]       HIGH_ADDRESS_PORT,
  output logic             ADDRESS_LATCH_STROBE,
  output logic             PROGRAM_FETCH_STROBE_N,
  output logic             DATA_READ_STROBE_N,
  output logic             DATA_WRITE_STROBE_N,
  // answers to the core
  output logic             FETCH_INTERNAL,
  output logic [15:0]      FETCH_PC,
  output logic             BUS_DONE,
  output logic [7:0]       BUS_RDATA,
  output logic             BUS_BUSY,
  // internal data decode results
  output mem_space_pkg::data_space_t IDATA_SPACE,
  output logic [7:0]       IDATA_EFF_ADDR,
  output logic             IDATA_IN_BANK_AREA,
  output logic             IDATA_IN_BIT_AREA,
  output logic             IDATA_SFR_BIT_OK,
  // status word
  output logic [7:0]       CORE_STATUS_WORD
);

  // bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_LATCH,
    ST_STROBE,
    ST_CAPTURE
  } bus_state_t;

  bus_state_t  state;            // sequencer state
  logic        cycle_is_fetch;   // current cycle is a code fetch
  logic        cycle_is_write;   // current cycle is a data write
  logic [15:0] cycle_addr;       // full address of current cycle
  logic [7:0]  cycle_wdata;      // data to write
  logic [2:0]  strap_sync;       // strap synchroniser, three stages
  logic        strap_n;          // filtered strap level
  logic [1:0]  bank_exec;        // bank frozen at instruction start
  logic [7:0]  psw_store;        // writable status bits
  logic [15:0] next_fetch_addr;  // fetch target after vector select
  logic        next_internal;    // fetch target lies in on-chip ROM
  mem_space_pkg::data_space_t dec_space;
  logic [7:0]  dec_eff;
  logic        dec_bank;
  logic        dec_bit;
  logic        dec_sfr;

  // strap is a pin: three stages, change accepted when last two agree
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      strap_sync <= 3'h7;
      strap_n <= 1'b1;
    end
    else
    begin
      strap_sync <= {strap_sync[1:0], EXTERNAL_FETCH_STRAP_N};
      if (strap_sync[2] == strap_sync[1])
        strap_n <= strap_sync[2];
    end
  end

  // fetch target: vectors override the program counter
  always_comb
  begin
    next_fetch_addr = FETCH_ADDR;
    if (VECTOR_REQ)
      // slot n at base plus n times eight
      next_fetch_addr = `VECTOR_BASE +
                        ({14'h0000, VECTOR_NUM} << 3);
    // internal only when strap high and top bits clear
    next_internal = strap_n &&
      (next_fetch_addr <= `INT_ROM_LAST);
  end

  // bus sequencer: address, latch, strobe, capture
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      state <= ST_IDLE;
      cycle_is_fetch <= 1'b0;
      cycle_is_write <= 1'b0;
      cycle_addr <= `RESET_VECTOR;
      cycle_wdata <= 8'h00;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // fetch has priority over data access
          if (FETCH_REQ && !next_internal)
          begin
            cycle_is_fetch <= 1'b1;
            cycle_is_write <= 1'b0;
            cycle_addr <= next_fetch_addr;
            state <= ST_ADDR;
          end
          else if (XDATA_REQ && !FETCH_REQ)
          begin
            cycle_is_fetch <= 1'b0;
            // program space is never written
            cycle_is_write <= XDATA_WRITE;
            cycle_addr <= XDATA_WIDE ? WIDE_DATA_POINTER
                          : {8'h00, XDATA_ADDR8};
            cycle_wdata <= XDATA_WDATA;
            state <= ST_ADDR;
          end
        end
        ST_ADDR:
          state <= ST_LATCH;
        ST_LATCH:
          state <= ST_STROBE;
        ST_STROBE:
          state <= ST_CAPTURE;
        ST_CAPTURE:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // pin drivers, all registered from the current state, one cycle behind it
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      MULTIPLEXED_LOW_PORT_OUT <= 8'h00;
      MULTIPLEXED_LOW_PORT_OE_N <= 1'b1;
      HIGH_ADDRESS_PORT <= 8'h00;
      ADDRESS_LATCH_STROBE <= 1'b0;
      PROGRAM_FETCH_STROBE_N <= 1'b1;
      DATA_READ_STROBE_N <= 1'b1;
      DATA_WRITE_STROBE_N <= 1'b1;
    end
    else
    begin
      case (state)
        ST_ADDR:
        begin
          // low byte on the port, latch strobe high
          MULTIPLEXED_LOW_PORT_OUT <= cycle_addr[7:0];
          MULTIPLEXED_LOW_PORT_OE_N <= 1'b0;
          HIGH_ADDRESS_PORT <= cycle_addr[15:8];
          ADDRESS_LATCH_STROBE <= 1'b1;
        end
        ST_LATCH:
        begin
          // strobe falls while address still held, latch keeps it
          ADDRESS_LATCH_STROBE <= 1'b0;
        end
        ST_STROBE:
        begin
          // port turns over only once the latch has closed, no hold race
          if (cycle_is_write)
            MULTIPLEXED_LOW_PORT_OUT <= cycle_wdata;
          else
            MULTIPLEXED_LOW_PORT_OE_N <= 1'b1;
          PROGRAM_FETCH_STROBE_N <= !cycle_is_fetch;
          DATA_READ_STROBE_N <= cycle_is_fetch || cycle_is_write;
          DATA_WRITE_STROBE_N <= !cycle_is_write;
        end
        default:
        begin
          // idle and capture: strobes off, port released
          ADDRESS_LATCH_STROBE <= 1'b0;
          PROGRAM_FETCH_STROBE_N <= 1'b1;
          DATA_READ_STROBE_N <= 1'b1;
          DATA_WRITE_STROBE_N <= 1'b1;
          MULTIPLEXED_LOW_PORT_OE_N <= 1'b1;
        end
      endcase
    end
  end

  // answers to the core; read data sampled while strobe active
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      BUS_DONE <= 1'b0;
      BUS_RDATA <= 8'h00;
      BUS_BUSY <= 1'b0;
      FETCH_INTERNAL <= 1'b0;
      FETCH_PC <= `RESET_VECTOR;
    end
    else
    begin
      BUS_DONE <= (state == ST_CAPTURE);
      BUS_BUSY <= (state != ST_IDLE) && (state != ST_CAPTURE);
      if (state == ST_CAPTURE && !cycle_is_write)
        BUS_RDATA <= MULTIPLEXED_LOW_PORT_IN;
      if (state == ST_IDLE && FETCH_REQ)
      begin
        // internal fetches complete without bus activity
        FETCH_INTERNAL <= next_internal;
        FETCH_PC <= next_fetch_addr;
      end
    end
  end

  // bank bits frozen as each instruction begins execution
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      bank_exec <= 2'h0;
    else if (INSTR_START)
      bank_exec <= {psw_store[`PSW_BANK_HIGH],
                    psw_store[`PSW_BANK_LOW]};
  end

  // status word storage; parity is not writable
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      psw_store <= `PSW_RESET;
    else if (PSW_WRITE)
      psw_store <= PSW_WDATA;
  end

  // status word output, parity recomputed every cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      CORE_STATUS_WORD <= `PSW_RESET;
    else
    begin
      CORE_STATUS_WORD <= psw_store;
      CORE_STATUS_WORD[`PSW_PARITY] <= ^ACCUMULATOR;
    end
  end

  // internal data decoder
  data_space_decode u_decode (
    .addr         (IDATA_ADDR),
    .indirect     (IDATA_INDIRECT),
    .reg_form     (IDATA_REG_FORM),
    .reg_num      (IDATA_REG_NUM),
    .bank         (bank_exec),
    .space        (dec_space),
    .eff_addr     (dec_eff),
    .in_bank_area (dec_bank),
    .in_bit_area  (dec_bit),
    .sfr_bit_ok   (dec_sfr)
  );

  // decode results registered so outputs come from flops
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      IDATA_SPACE <= mem_space_pkg::SPACE_LOWER;
      IDATA_EFF_ADDR <= 8'h00;
      IDATA_IN_BANK_AREA <= 1'b0;
      IDATA_IN_BIT_AREA <= 1'b0;
      IDATA_SFR_BIT_OK <= 1'b0;
    end
    else
    begin
      IDATA_SPACE <= dec_space;
      IDATA_EFF_ADDR <= dec_eff;
      IDATA_IN_BANK_AREA <= dec_bank;
      IDATA_IN_BIT_AREA <= dec_bit;
      IDATA_SFR_BIT_OK <= dec_sfr;
    end
  end
endmodule

// [design/mem_space_defines.svh]
/*
  Constants for the memory-space decoder: program map boundaries,
  interrupt vector slots, internal data map and status word layout.
  Assumes inclusion by bare name from the design files.
*/
`ifndef MEM_SPACE_DEFINES_SVH
`define MEM_SPACE_DEFINES_SVH

// program memory map
`define RESET_VECTOR      16'h0000
`define VECTOR_BASE       16'h0003
`define VECTOR_STRIDE     16'h0008
`define INT_ROM_LAST      16'h0fff
`define INT_ROM_TOP_BITS  4
// internal data map
`define LOWER_LAST        8'h7f
`define BANK_AREA_LAST    8'h1f
`define BIT_AREA_FIRST    8'h20
`define BIT_AREA_LAST     8'h2f
`define BANK_SIZE_SHIFT   3
// status word bit positions
`define PSW_CARRY         7
`define PSW_AUX_CARRY     6
`define PSW_USER0         5
`define PSW_BANK_HIGH     4
`define PSW_BANK_LOW      3
`define PSW_OVERFLOW      2
`define PSW_USER1         1
`define PSW_PARITY        0
`define PSW_RESET         8'h00

`endif

// [design/mem_space_pkg.sv]
/*
  Types shared by the memory-space decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mem_space_pkg;
  // data space a decoded internal access lands in
  typedef enum logic [1:0] {
    SPACE_LOWER,
    SPACE_UPPER,
    SPACE_SPECIAL
  } data_space_t;
endpackage

// [verification/ext_memory_model.sv]
/* external code store, data store and address latch
   assumes the decoder pins wired straight to it */
`timescale 1ns/1ps
module ext_memory_model (
  // clock
  input  wire logic       clk,
  // decoder pins
  input  wire logic       ale,
  input  wire logic [7:0] lo_out,
  input  wire logic       lo_oe_n,
  input  wire logic [7:0] hi,
  input  wire logic       program_fetch_strobe_n_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  // resolved low port level
  output logic      [7:0] lo_in
);
  logic [7:0] latch;         // latched low address
  logic [7:0] junk = 8'h3c;  // floating port pattern
  logic [7:0] ram [0:65535]; // data store
  // latch and write on the clock
  always @(posedge clk)
  begin
    if (ale)
      latch <= lo_out;
    if (!wr_n)
      ram[{hi, latch}] <= lo_out;
    junk <= junk + 8'h35;
  end
  // a floating port keeps changing, so a late sample never passes
  always_comb
  begin
    if (!lo_oe_n)
      lo_in = lo_out;
    else if (!program_fetch_strobe_n_n)
      lo_in = hi ^ latch ^ 8'h5a;
    else if (!rd_n)
      lo_in = ram[{hi, latch}];
    else
      lo_in = junk;
  end
endmodule

// [verification/mem_space_assertions.sv]
/* pin checks for mem_space_decoder
   assumes binding to its ports by name */
`timescale 1ns/1ps
module mem_space_checker (
  // clock, reset
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  // core side
  input wire logic [7:0] ACCUMULATOR,
  input wire logic [7:0] IDATA_ADDR,
  input wire logic       IDATA_INDIRECT,
  input wire logic       IDATA_REG_FORM,
  // pins, answers
  input wire logic       MULTIPLEXED_LOW_PORT_OE_N,
  input wire logic [7:0] MULTIPLEXED_LOW_PORT_OUT,
  input wire logic       ADDRESS_LATCH_STROBE,
  input wire logic       PROGRAM_FETCH_STROBE_N,
  input wire logic       DATA_READ_STROBE_N,
  input wire logic       DATA_WRITE_STROBE_N,
  input wire logic       BUS_DONE,
  input wire logic [7:0] CORE_STATUS_WORD,
  input wire mem_space_pkg::data_space_t IDATA_SPACE
);
  // active strobes: fetch, read, write
  wire [2:0] act = ~{PROGRAM_FETCH_STROBE_N, DATA_READ_STROBE_N,
                     DATA_WRITE_STROBE_N};
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  a_ale_one_cycle: assert property (
    ADDRESS_LATCH_STROBE |=> !ADDRESS_LATCH_STROBE)
    else $error("latch strobe too long");
  a_ale_port_drv: assert property (
    ADDRESS_LATCH_STROBE |-> !MULTIPLEXED_LOW_PORT_OE_N)
    else $error("address not driven under latch strobe");
  a_strobe_slot: assert property (
    ADDRESS_LATCH_STROBE |-> ##2 $onehot(act))
    else $error("no strobe two cycles after latch");
  a_done_slot: assert property (
    $rose(ADDRESS_LATCH_STROBE) |-> ##3 BUS_DONE)
    else $error("cycle end misplaced");
  a_port_floats: assert property (
    act[2] || act[1] |-> MULTIPLEXED_LOW_PORT_OE_N)
    else $error("port driven during a read");
  a_one_strobe: assert property (
    $onehot0(act))
    else $error("two strobes at once");
  a_parity_track: assert property (
    $past(RST_N) |-> CORE_STATUS_WORD[0] == ^$past(ACCUMULATOR))
    else $error("parity flag wrong");
  // direct upper addresses land in specials, indirect in upper ram
  a_upper_split: assert property (
    $past(RST_N) && $past(IDATA_ADDR[7]) && !$past(IDATA_REG_FORM)
    |-> IDATA_SPACE == ($past(IDATA_INDIRECT) ?
    mem_space_pkg::SPACE_UPPER : mem_space_pkg::SPACE_SPECIAL))
    else $error("upper address space wrong");
  // the address must still stand on the port as the latch closes
  a_latch_hold: assert property (
    $fell(ADDRESS_LATCH_STROBE) |->
    !MULTIPLEXED_LOW_PORT_OE_N && $stable(MULTIPLEXED_LOW_PORT_OUT))
    else $error("port moved as latch strobe fell");
endmodule

bind mem_space_decoder mem_space_checker i_mem_space_checker (.*);

// [verification/test_mem_space_decoder.sv]
/* bench for mem_space_decoder and the memory model
   assumes the checker is bound to the decoder */
`timescale 1ns/1ps
module test_mem_space_decoder;
  typedef struct {logic [15:0] a; logic [2:0] k; logic [7:0] d;} note_t;
  logic        clk = 0, rst_n = 0, strap_n = 1;
  logic        freq = 0, vreq = 0, xreq = 0, xwr = 0, xwide = 0;
  logic        iind = 0, iform = 0, istart = 0, pswwr = 0;
  logic [1:0]  vnum = 0, bank = 0;
  logic [2:0]  inum = 0;
  logic [7:0]  xa8 = 0, wdat = 0, ia = 0, acc = 0, pswd = 0;
  logic [15:0] faddr = 0, wide_data_pointer = 0;
  wire  [7:0]  lo_out, lo_in, hi, rdata, eff, core_status_word;
  wire  [15:0] f_pc;
  wire         ale, oe_n, program_fetch_strobe_n_n, rd_n, wr_n, f_int, done, ibk, ibit, special_register_space;
  wire         busy;
  mem_space_pkg::data_space_t space;
  note_t       q[$], seen, top, r; // queued and observed bus cycles
  int          fail_count = 0, num_checks = 0, cyc = 0;
  logic [7:0]  tbl [10] = '{8'h00, 8'h1f, 8'h20, 8'h2f, 8'h30,
                            8'h7f, 8'h80, 8'h88, 8'h8b, 8'hff};
  mem_space_decoder i_mem_space_decoder (
    .SYS_CLK(clk), .RST_N(rst_n), .EXTERNAL_FETCH_STRAP_N(strap_n),
    .FETCH_REQ(freq), .FETCH_ADDR(faddr), .VECTOR_REQ(vreq),
    .VECTOR_NUM(vnum), .XDATA_REQ(xreq), .XDATA_WRITE(xwr),
    .XDATA_WIDE(xwide), .XDATA_ADDR8(xa8), .WIDE_DATA_POINTER(wide_data_pointer),
    .XDATA_WDATA(wdat), .IDATA_ADDR(ia), .IDATA_INDIRECT(iind),
    .IDATA_REG_FORM(iform), .IDATA_REG_NUM(inum), .INSTR_START(istart),
    .ACCUMULATOR(acc), .PSW_WRITE(pswwr), .PSW_WDATA(pswd),
    .MULTIPLEXED_LOW_PORT_IN(lo_in), .MULTIPLEXED_LOW_PORT_OUT(lo_out),
    .MULTIPLEXED_LOW_PORT_OE_N(oe_n), .HIGH_ADDRESS_PORT(hi),
    .ADDRESS_LATCH_STROBE(ale), .PROGRAM_FETCH_STROBE_N(program_fetch_strobe_n_n),
    .DATA_READ_STROBE_N(rd_n), .DATA_WRITE_STROBE_N(wr_n),
    .FETCH_INTERNAL(f_int), .FETCH_PC(f_pc), .BUS_DONE(done),
    .BUS_RDATA(rdata), .BUS_BUSY(busy), .IDATA_SPACE(space),
    .IDATA_EFF_ADDR(eff), .IDATA_IN_BANK_AREA(ibk),
    .IDATA_IN_BIT_AREA(ibit), .IDATA_SFR_BIT_OK(special_register_space),
    .CORE_STATUS_WORD(core_status_word));
  ext_memory_model i_ext_memory_model (
    .clk(clk), .ale(ale), .lo_out(lo_out), .lo_oe_n(oe_n), .hi(hi),
    .program_fetch_strobe_n_n(program_fetch_strobe_n_n), .rd_n(rd_n), .wr_n(wr_n), .lo_in(lo_in));
  always #50 clk = ~clk;
  // compare and count
  task automatic cmp(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic close_out;
    cmp(16'(q.size()), 0);
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // next edge, fresh accumulator so parity keeps moving
  task automatic go;
    @(posedge clk);
    acc <= 8'($urandom);
  endtask
  // one external cycle: note it, request it, wait five edges, watch busy
  task automatic bus(input logic [2:0] k, input logic [15:0] a,
                     input logic [7:0] d);
    q.push_back('{a, k, k[2] ? a[15:8] ^ a[7:0] ^ 8'h5a : d});
    go;
    {freq, xreq, xwr, xwide} <= {k[2], !k[2], k[0], |a[15:8]};
    {wide_data_pointer, xa8, wdat, faddr} <= {a, a[7:0], d, a};
    go;
    {freq, xreq} <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
    cmp(busy, 1);
    repeat (3) @(posedge clk);
    #1;
    cmp(busy, 0);
    if (k[2])
    begin
      cmp(f_int, 0);
      cmp(f_pc, a);
    end
  endtask
  // internal fetch, plain or vectored: no pin may move
  task automatic ifetch(input logic [15:0] a, input logic v,
                        input logic [1:0] n);
    go;
    {freq, vreq, vnum, faddr} <= {1'b1, v, n, v ? ~a : a};
    go;
    {freq, vreq} <= 2'h0;
    go;
    #1;
    cmp(f_int, 1);
    cmp(f_pc, a);
  endtask
  // internal data access, result a cycle later
  task automatic dec(input logic [7:0] a, input logic ind, form);
    logic [7:0] e;
    e = form ? {3'h0, bank, a[2:0]} : a;
    go;
    {ia, iind, iform, inum} <= {a, ind, form, a[2:0]};
    go;
    #1;
    cmp(space, form || !a[7] ? 0 : ind ? 1 : 2);
    cmp(eff, e);
    cmp(ibk, e < 8'h20);
    cmp(ibit, e[7:4] == 4'h2);
    cmp(special_register_space, !form && !ind && a[7] && a[2:0] == 0);
  endtask
  // write status word, then start an instruction to freeze the bank
  task automatic setbank(input logic [1:0] b);
    logic [7:0] w;
    w = 8'($urandom);
    w[4:3] = b;
    go;
    {pswwr, pswd} <= {1'b1, w};
    go;
    pswwr <= 0;
    go;
    go;
    istart <= 1;
    go;
    istart <= 0;
    bank = b;
    #1;
    cmp(core_status_word[7:1], w[7:1]);
    // a bank change with no new instruction must not take effect
    w[4:3] = ~b;
    go;
    {pswwr, pswd} <= {1'b1, w};
    go;
    pswwr <= 0;
  endtask
  // bus watcher: address at the latch strobe, strobe kind, judge at end
  always @(posedge clk)
  begin
    if (ale)
      seen.a = {hi, lo_out};
    if (!program_fetch_strobe_n_n || !rd_n || !wr_n)
      seen.k = ~{program_fetch_strobe_n_n, rd_n, wr_n};
    if (done && q.size() == 0)
      cmp(1, 0);
    else if (done)
    begin
      top = q.pop_front();
      cmp(seen.a, top.a);
      cmp(seen.k, top.k);
      if (!top.k[0])
        cmp(rdata, top.d);
      seen.k = 0;
    end
  end
  // hang guard, far beyond the run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      close_out;
    end
  end
  initial
  begin
    void'($urandom(26));
    repeat (20) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    ifetch(16'h0000, 0, 0);
    ifetch(16'h0fff, 0, 0);
    for (int n = 0; n < 4; n++)
      ifetch(16'h0003 + 16'(8 * n), 1, 2'(n));
    bus(3'b100, 16'h1000, 0);
    bus(3'b100, 16'hffff, 0);
    // reset again mid-run: fetch address and pins back to rest
    go;
    rst_n <= 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    go;
    #1;
    cmp(f_pc, 16'h0000);
    cmp({ale, program_fetch_strobe_n_n, rd_n, wr_n, oe_n}, 5'h0f);
    for (int i = 0; i < 6; i++)
    begin
      r.a = 16'($urandom) & (i[0] ? 16'h00ff : 16'hffff);
      r.d = 8'($urandom);
      bus(3'b001, r.a, r.d);
      bus(3'b010, r.a, r.d);
    end
    go;
    strap_n <= 0;
    repeat (5) @(posedge clk);
    bus(3'b100, 16'h0000, 0);
    bus(3'b100, 16'h0fff & 16'($urandom), 0);
    foreach (tbl[j])
    begin
      dec(tbl[j], 0, 0);
      dec(tbl[j], 1, 0);
    end
    for (int b = 0; b < 4; b++)
    begin
      setbank(2'(b));
      dec(8'($urandom), 0, 1);
    end
    close_out;
  end
endmodule
